//--- tsc_consts.svh
// Operation
// - The nanoseconds and seconds sample registers show the timestamp unit chosen by unit pointer bit 8.
// - Bit 30 of the fourth nanoseconds register is one for a rising event edge, zero for falling, reset zero.
// - Bits 29:0 of the fourth nanoseconds register hold the read-only nanoseconds, reset zero.
// - The fourth seconds register holds the read-only 32-bit seconds, reset zero.
// - The fourth phase bits 2:0 code the 8ns slot as 000, 001, 010, 011, 100 for 0 to 32ns; 101-111 unused.
// - The slot code is the capture position among five 8ns slots of one 40ns timing-clock period.
// - Bit 30 of the fifth nanoseconds register is one for a rising event edge, zero for falling, reset zero.
// - Bits 29:0 of the fifth nanoseconds register hold the read-only nanoseconds, reset zero.
// - The fifth seconds register holds the read-only 32-bit seconds, reset zero.
// - The fifth phase bits 2:0 use the same slot code, with bits 31:3 reading zero.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// register byte offsets
`define TSC_OFS_UNIT_INDEX 12'h500
`define TSC_OFS_CTRL 12'h504
`define TSC_OFS_STATUS 12'h508
`define TSC_OFS_MASK 12'h50c
`define TSC_OFS_S4_NS 12'h578
`define TSC_OFS_S4_SEC 12'h57c
`define TSC_OFS_S4_PHASE 12'h580
`define TSC_OFS_S5_NS 12'h584
`define TSC_OFS_S5_SEC 12'h588
`define TSC_OFS_S5_PHASE 12'h58c
`define TSC_ADDR_W 12

// field positions
`define TSC_UNIT_PTR_BIT 8
`define TSC_POL_BIT 30
`define TSC_CTRL_RISE_BIT 0
`define TSC_CTRL_FALL_BIT 1
`define TSC_CTRL_REARM_BIT 4
`define TSC_CTRL_CNT_LSB 8

// sizes and reset values
`define TSC_NUM_UNITS 2
`define TSC_CNT_W 4
`define TSC_MAX_SAMPLES 4'h8
`define TSC_IDX_S4 4'h3
`define TSC_IDX_S5 4'h4
`define TSC_CTRL_RST 2'h3
`define TSC_ZERO32 32'h0000_0000

// 8ns slot codes inside one 40ns period
`define TSC_SLOT_0NS 3'h0
`define TSC_SLOT_8NS 3'h1
`define TSC_SLOT_16NS 3'h2
`define TSC_SLOT_24NS 3'h3
`define TSC_SLOT_32NS 3'h4

`endif

//--- tsc_pkg.sv
package tsc_pkg;
    // one captured sample
    typedef struct packed {
        logic pol;
        logic [29:0] ns;
        logic [31:0] sec;
        logic [2:0] slot;
    } tsc_sample_s;

    // bus answer state, one-hot
    typedef enum logic [1:0] {
        TSC_IDLE = 2'b01,
        TSC_ACK = 2'b10
    } tsc_bus_e;
endpackage

//--- tsc_cap_if.sv
`timescale 1ns/1ps
interface tsc_cap_if;
    logic rise;
    logic fall;
    logic rearm;
    logic rise_en;
    logic fall_en;
    logic [31:0] sec;
    logic [29:0] ns;
    logic [2:0] slot;
    tsc_pkg::tsc_sample_s s4;
    tsc_pkg::tsc_sample_s s5;
    logic [3:0] count;
    logic cap4;
    logic cap5;

    modport unit(input rise, fall, rearm, rise_en, fall_en, sec, ns, slot, output s4, s5, count, cap4, cap5);
    modport ctl(output rise, fall, rearm, rise_en, fall_en, sec, ns, slot, input s4, s5, count, cap4, cap5);
endinterface

//--- tsc_sync.sv
`timescale 1ns/1ps
module tsc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous event pin
    input wire logic pin,
    // one-cycle edge pulses
    output logic rise,
    output logic fall
);

    logic meta_r, meta_nxt;
    logic stable_r, stable_nxt;
    logic prev_r, prev_nxt;

    // two stages before anything looks at the pin; prev gives edge detection
    always_comb begin
        meta_nxt = pin;
        stable_nxt = meta_r;
        prev_nxt = stable_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            stable_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            stable_r <= stable_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign rise = stable_r & ~prev_r;
    assign fall = ~stable_r & prev_r;

endmodule

//--- tsc_unit.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"
module tsc_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // capture carrier
    tsc_cap_if.unit cap
);

    logic [3:0] cnt_r, cnt_nxt;
    tsc_pkg::tsc_sample_s s4_r, s4_nxt, s5_r, s5_nxt;
    tsc_pkg::tsc_sample_s snap;
    logic hit;
    logic [2:0] slot_code;

    // map slot position to its code; unused positions fold to slot zero
    always_comb begin
        case (cap.slot)
            3'h0: slot_code = `TSC_SLOT_0NS;
            3'h1: slot_code = `TSC_SLOT_8NS;
            3'h2: slot_code = `TSC_SLOT_16NS;
            3'h3: slot_code = `TSC_SLOT_24NS;
            3'h4: slot_code = `TSC_SLOT_32NS;
            default: slot_code = `TSC_SLOT_0NS;
        endcase
    end

    // qualified edge; counting stops at TSC_MAX_SAMPLES, eight edges, past the fifth sample slot
    assign hit = ((cap.rise & cap.rise_en) | (cap.fall & cap.fall_en)) && (cnt_r < `TSC_MAX_SAMPLES);
    assign snap = '{pol: cap.rise, ns: cap.ns, sec: cap.sec, slot: slot_code};

    // sample counter and the two sample slots held here
    always_comb begin
        cnt_nxt = cnt_r;
        s4_nxt = s4_r;
        s5_nxt = s5_r;
        if (cap.rearm) begin
            cnt_nxt = '0;
        end else if (hit) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == `TSC_IDX_S4) begin
                s4_nxt = snap;
            end
            if (cnt_r == `TSC_IDX_S5) begin
                s5_nxt = snap;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            s4_r <= '0;
            s5_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            s4_r <= s4_nxt;
            s5_r <= s5_nxt;
        end
    end

    assign cap.s4 = s4_r;
    assign cap.s5 = s5_r;
    assign cap.count = cnt_r;
    assign cap.cap4 = hit & ~cap.rearm & (cnt_r == `TSC_IDX_S4);
    assign cap.cap5 = hit & ~cap.rearm & (cnt_r == `TSC_IDX_S5);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_cap4_fields: assert property (@(posedge clk) disable iff (rst)
        cap.cap4 |=> (s4_r.sec == $past(cap.sec)) && (s4_r.ns == $past(cap.ns)) && (s4_r.pol == $past(cap.rise)))
        else $error("fourth sample not latched");
    a_cap5_fields: assert property (@(posedge clk) disable iff (rst)
        cap.cap5 |=> (s5_r.sec == $past(cap.sec)) && (s5_r.ns == $past(cap.ns)) && (s5_r.pol == $past(cap.rise)))
        else $error("fifth sample not latched");
    a_slot_legal: assert property (@(posedge clk) disable iff (rst)
        (s4_r.slot <= `TSC_SLOT_32NS) && (s5_r.slot <= `TSC_SLOT_32NS))
        else $error("reserved slot code held");
    a_s4_hold: assert property (@(posedge clk) disable iff (rst)
        !cap.cap4 |=> $stable(s4_r))
        else $error("fourth sample changed without capture");
    a_count_step: assert property (@(posedge clk) disable iff (rst)
        hit && !cap.rearm |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("sample counter did not advance");
    c_fifth_seen: cover property (@(posedge clk) disable iff (rst) cap.cap5);

endmodule

//--- tsc_top.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "tsc_consts.svh"
module tsc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [11:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // event pins, one per timestamp unit
    input wire logic [1:0] event_in,
    // timing clock value, same clock domain
    input wire logic [31:0] time_sec,
    input wire logic [29:0] time_ns,
    input wire logic [2:0] time_slot,
    // interrupt
    output logic irq
);

    // status and mask hold two flags per unit: fourth and fifth capture
    localparam int NU = `TSC_NUM_UNITS;
    localparam int SW = 2 * `TSC_NUM_UNITS;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    tsc_pkg::tsc_bus_e state_r, state_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic unit_sel_r, unit_sel_nxt;
    logic rise_en_r, rise_en_nxt;
    logic fall_en_r, fall_en_nxt;
    logic [SW-1:0] status_r, status_nxt;
    logic [SW-1:0] mask_r, mask_nxt;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic wr_go;
    logic rearm_go;
    logic [31:0] rd_mux;
    logic [SW-1:0] cap_ev;
    logic [1:0] ev_rise;
    logic [1:0] ev_fall;
    tsc_pkg::tsc_sample_s sel4;
    tsc_pkg::tsc_sample_s sel5;
    logic [3:0] sel_count;

    tsc_cap_if cap_bus [NU] ();

    ////////////////////////////////////////////////////////////////////////////
    // per-unit synchronisers and capture units

    for (genvar u = 0; u < NU; u++) begin : g_unit
        tsc_sync u_sync (
            .clk(clk),
            .rst(rst),
            .pin(event_in[u]),
            .rise(ev_rise[u]),
            .fall(ev_fall[u])
        );

        // timing value and edge enables fan out to every unit
        assign cap_bus[u].rise = ev_rise[u];
        assign cap_bus[u].fall = ev_fall[u];
        assign cap_bus[u].rise_en = rise_en_r;
        assign cap_bus[u].fall_en = fall_en_r;
        // rearm reaches only the unit that the pointer selects
        assign cap_bus[u].rearm = rearm_go && (unit_sel_r == 1'(u));
        assign cap_bus[u].sec = time_sec;
        assign cap_bus[u].ns = time_ns;
        assign cap_bus[u].slot = time_slot;
        assign cap_ev[2*u] = cap_bus[u].cap4;
        assign cap_ev[2*u+1] = cap_bus[u].cap5;

        tsc_unit u_unit (
            .clk(clk),
            .rst(rst),
            .cap(cap_bus[u])
        );
    end

    // unit pointer picks whose samples software sees
    always_comb begin
        if (unit_sel_r) begin
            sel4 = cap_bus[1].s4;
            sel5 = cap_bus[1].s5;
            sel_count = cap_bus[1].count;
        end else begin
            sel4 = cap_bus[0].s4;
            sel5 = cap_bus[0].s5;
            sel_count = cap_bus[0].count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    // unmapped offsets and reserved bits read zero
    always_comb begin
        rd_mux = `TSC_ZERO32;
        case (address)
            `TSC_OFS_UNIT_INDEX: rd_mux[`TSC_UNIT_PTR_BIT] = unit_sel_r;
            `TSC_OFS_CTRL: begin
                rd_mux[`TSC_CTRL_RISE_BIT] = rise_en_r;
                rd_mux[`TSC_CTRL_FALL_BIT] = fall_en_r;
                rd_mux[`TSC_CTRL_CNT_LSB +: `TSC_CNT_W] = sel_count;
            end
            `TSC_OFS_STATUS: rd_mux[SW-1:0] = status_r;
            `TSC_OFS_MASK: rd_mux[SW-1:0] = mask_r;
            `TSC_OFS_S4_NS: rd_mux = {1'b0, sel4.pol, sel4.ns};
            `TSC_OFS_S4_SEC: rd_mux = sel4.sec;
            `TSC_OFS_S4_PHASE: rd_mux[2:0] = sel4.slot;
            `TSC_OFS_S5_NS: rd_mux = {1'b0, sel5.pol, sel5.ns};
            `TSC_OFS_S5_SEC: rd_mux = sel5.sec;
            `TSC_OFS_S5_PHASE: rd_mux[2:0] = sel5.slot;
            default: rd_mux = `TSC_ZERO32;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: request held one cycle, answered in the next

    // read data are sampled on the first cycle so they stand during the answer cycle
    always_comb begin
        state_nxt = state_r;
        rdata_nxt = rdata_r;
        case (state_r)
            tsc_pkg::TSC_IDLE: begin
                if (read || write) begin
                    state_nxt = tsc_pkg::TSC_ACK;
                    rdata_nxt = read ? rd_mux : `TSC_ZERO32;
                end
            end
            tsc_pkg::TSC_ACK: state_nxt = tsc_pkg::TSC_IDLE;
            default: state_nxt = tsc_pkg::TSC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= tsc_pkg::TSC_IDLE;
            rdata_r <= `TSC_ZERO32;
        end else begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // one wait state per access; a write dropped before its answer cycle is lost
    assign waitrequest = (read || write) && (state_r != tsc_pkg::TSC_ACK);
    assign readdata = rdata_r;
    assign wr_go = write && (state_r == tsc_pkg::TSC_ACK);
    assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wbits = writedata & wmask;
    assign rearm_go = wr_go && (address == `TSC_OFS_CTRL) && wbits[`TSC_CTRL_REARM_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // control, status and mask registers

    // a capture in the same cycle as a clearing write keeps its status bit
    always_comb begin
        unit_sel_nxt = unit_sel_r;
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        status_nxt = status_r;
        mask_nxt = mask_r;
        if (wr_go) begin
            case (address)
                `TSC_OFS_UNIT_INDEX: begin
                    if (byteenable[1]) begin
                        unit_sel_nxt = writedata[`TSC_UNIT_PTR_BIT];
                    end
                end
                `TSC_OFS_CTRL: begin
                    if (byteenable[0]) begin
                        rise_en_nxt = writedata[`TSC_CTRL_RISE_BIT];
                        fall_en_nxt = writedata[`TSC_CTRL_FALL_BIT];
                    end
                end
                `TSC_OFS_STATUS: status_nxt = status_r & ~wbits[SW-1:0];
                `TSC_OFS_MASK: mask_nxt = (mask_r & ~wmask[SW-1:0]) | wbits[SW-1:0];
                default: status_nxt = status_r;
            endcase
        end
        status_nxt = status_nxt | cap_ev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            unit_sel_r <= 1'b0;
            rise_en_r <= 1'(`TSC_CTRL_RST >> `TSC_CTRL_RISE_BIT);
            fall_en_r <= 1'(`TSC_CTRL_RST >> `TSC_CTRL_FALL_BIT);
            status_r <= '0;
            mask_r <= '0;
        end else begin
            unit_sel_r <= unit_sel_nxt;
            rise_en_r <= rise_en_nxt;
            fall_en_r <= fall_en_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
        end
    end

    // level interrupt while any unmasked capture flag stands
    assign irq = |(status_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer later than one cycle");
    a_sel_ns_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_S4_NS |=> readdata == {1'b0, $past(sel4.pol), $past(sel4.ns)})
        else $error("fourth nanoseconds read wrong");
    a_sec5_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_S5_SEC |=> readdata == $past(sel5.sec))
        else $error("fifth seconds read wrong");
    a_phase_upper: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && (address == `TSC_OFS_S4_PHASE || address == `TSC_OFS_S5_PHASE)
        |=> readdata[31:3] == 29'h0)
        else $error("phase reserved bits not zero");
    a_status_set: assert property (@(posedge clk) disable iff (rst)
        |cap_ev |=> (status_r & $past(cap_ev)) == $past(cap_ev))
        else $error("capture flag lost");
    a_irq_follow: assert property (@(posedge clk) disable iff (rst)
        (|cap_ev) && ((cap_ev & mask_r) != '0) && !wr_go |=> irq)
        else $error("unmasked capture gave no interrupt");
    c_read_s4: cover property (@(posedge clk) disable iff (rst) read && !waitrequest && address == `TSC_OFS_S4_NS);
    c_unit1_sel: cover property (@(posedge clk) disable iff (rst) unit_sel_r && cap_ev[2]);
    c_irq_up: cover property (@(posedge clk) disable iff (rst) $rose(irq));
    c_count_full: cover property (@(posedge clk) disable iff (rst) sel_count == `TSC_MAX_SAMPLES);

    // reset values; enables come out of reset set so captures run before any setup write
    a_rst_regs: assert property (@(posedge clk)
        rst |=> !unit_sel_r && rise_en_r && fall_en_r)
        else $error("control registers not at reset values");
    a_rst_flags: assert property (@(posedge clk)
        rst |=> (status_r == '0) && (mask_r == '0) && !irq)
        else $error("flags or interrupt not cleared by reset");
    a_rst_bus: assert property (@(posedge clk)
        rst |=> (state_r == tsc_pkg::TSC_IDLE) && (readdata == `TSC_ZERO32))
        else $error("bus side not idle after reset");

    // read data follow the selected unit
    a_s4_sec_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_S4_SEC |=> readdata == $past(sel4.sec))
        else $error("fourth seconds read wrong");
    a_s4_phase_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_S4_PHASE
        |=> readdata[2:0] == $past(sel4.slot))
        else $error("fourth phase read wrong");
    a_s5_ns_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_S5_NS
        |=> readdata == {1'b0, $past(sel5.pol), $past(sel5.ns)})
        else $error("fifth nanoseconds read wrong");
    a_s5_phase_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_S5_PHASE
        |=> readdata[2:0] == $past(sel5.slot))
        else $error("fifth phase read wrong");
    a_ns_top_zero: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && (address == `TSC_OFS_S4_NS || address == `TSC_OFS_S5_NS) |=> !readdata[31])
        else $error("nanoseconds reserved bit set");
    a_unit_rd: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_UNIT_INDEX
        |=> readdata[`TSC_UNIT_PTR_BIT] == $past(unit_sel_r))
        else $error("unit pointer read wrong");
    a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
        read && waitrequest && address == `TSC_OFS_CTRL
        |=> readdata[`TSC_CTRL_CNT_LSB +: `TSC_CNT_W] == $past(sel_count))
        else $error("sample count read wrong");
    a_write_zero: assert property (@(posedge clk) disable iff (rst)
        write && waitrequest |=> readdata == `TSC_ZERO32)
        else $error("write answered with data");

    // writes and their effects
    a_unit_ptr: assert property (@(posedge clk) disable iff (rst)
        wr_go && address == `TSC_OFS_UNIT_INDEX && byteenable[1]
        |=> unit_sel_r == $past(writedata[`TSC_UNIT_PTR_BIT]))
        else $error("unit pointer write lost");
    a_sample_ro: assert property (@(posedge clk) disable iff (rst)
        wr_go && (address >= `TSC_OFS_S4_NS) && (address <= `TSC_OFS_S5_PHASE) && (cap_ev == '0)
        |=> $stable(sel4) && $stable(sel5))
        else $error("sample register changed by a write");
    a_w1c_clear: assert property (@(posedge clk) disable iff (rst)
        wr_go && address == `TSC_OFS_STATUS && (cap_ev == '0)
        |=> (status_r & $past(wbits[SW-1:0])) == '0)
        else $error("status bit not cleared by a one");
    a_rearm_zero: assert property (@(posedge clk) disable iff (rst)
        rearm_go |=> sel_count == 4'h0)
        else $error("rearm left a sample count");

    // capture side
    a_edge_off: assert property (@(posedge clk) disable iff (rst)
        !rise_en_r && !fall_en_r |-> cap_ev == '0)
        else $error("capture with both edges disabled");
    a_count_cap: assert property (@(posedge clk) disable iff (rst)
        sel_count <= `TSC_MAX_SAMPLES)
        else $error("sample count beyond its last slot");

endmodule

//--- tsc_evsrc.sv
`timescale 1ns/1ps
module tsc_evsrc (
    // clock
    input wire logic clk,
    // event pins and timing-clock value
    output logic [1:0] event_in,
    output logic [31:0] time_sec,
    output logic [29:0] time_ns,
    output logic [2:0] time_slot
);
    // quiet pins and a zero time until the first event
    initial begin
        event_in = 2'h0;
        time_sec = 32'h0000_0000;
        time_ns = 30'h0000_0000;
        time_slot = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one pin transition; the time stays put for six clocks, so whatever the
    // synchroniser latency the capture sees exactly this value
    task automatic edge_at(input int u, input logic [31:0] s, input logic [29:0] n, input logic [2:0] sl);
        time_sec <= s;
        time_ns <= n;
        time_slot <= sl; // position among the five 8ns slots
        event_in[u] <= ~event_in[u];
        repeat (6) @(posedge clk);
    endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    logic clk, rst, read, write, waitrequest, irq;
    logic [11:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic [1:0] event_in;
    logic [31:0] time_sec;
    logic [29:0] time_ns;
    logic [2:0] time_slot;
    integer seed = 32'h5f48;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    tsc_pkg::tsc_sample_s exp_s [2][2];

    // block under test and the event source
    tsc_top dut_u (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .event_in(event_in), .time_sec(time_sec),
        .time_ns(time_ns), .time_slot(time_slot), .irq(irq));
    tsc_evsrc src_u (.clk(clk), .event_in(event_in), .time_sec(time_sec), .time_ns(time_ns),
        .time_slot(time_slot));

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard: the whole run needs a few thousand cycles at most
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one avalon access; the request is held until waitrequest is seen low,
    // then an idle cycle so the strobes never toggle twice in one step
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        int waits = 0;
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clk);
            waits++;
        end while (waitrequest !== 1'b0);
        rd = readdata;
        `CHK("wait_edges", 2, waits)
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        `CHK(nm, e, rd)
    endtask

    // expected register words, built from the field layout
    function automatic logic [31:0] ns_word(tsc_pkg::tsc_sample_s s);
        return {1'b0, s.pol, s.ns};
    endfunction

    function automatic logic [31:0] ph_word(tsc_pkg::tsc_sample_s s);
        return (s.slot > 3'h4) ? 32'h0000_0000 : {29'h0, s.slot};
    endfunction

    // select a unit and read back both of its samples
    task automatic check_unit(input int u);
        bus(1'b1, `TSC_OFS_UNIT_INDEX, 32'(u) << `TSC_UNIT_PTR_BIT, 4'hf);
        rd_chk(`TSC_OFS_S4_NS, ns_word(exp_s[u][0]), "s4_ns");
        rd_chk(`TSC_OFS_S4_SEC, exp_s[u][0].sec, "s4_sec");
        rd_chk(`TSC_OFS_S4_PHASE, ph_word(exp_s[u][0]), "s4_phase");
        rd_chk(`TSC_OFS_S5_NS, ns_word(exp_s[u][1]), "s5_ns");
        rd_chk(`TSC_OFS_S5_SEC, exp_s[u][1].sec, "s5_sec");
        rd_chk(`TSC_OFS_S5_PHASE, ph_word(exp_s[u][1]), "s5_phase");
    endtask

    // rearm a unit and send five alternating edges; slots of samples four
    // and five step through every code over rounds 0..2, and the last
    // round stores a reserved position that must read back as code 000
    task automatic round(input int u, input int r);
        tsc_pkg::tsc_sample_s s;
        bus(1'b1, `TSC_OFS_UNIT_INDEX, 32'(u) << `TSC_UNIT_PTR_BIT, 4'hf);
        bus(1'b1, `TSC_OFS_CTRL, 32'h0000_0013, 4'hf);
        for (int k = 0; k < 5; k++) begin
            s.pol = ~event_in[u];
            s.sec = $random(seed);
            s.ns = 30'($random(seed));
            s.slot = (k < 3) ? 3'($unsigned($random(seed)) % 5) : 3'((2 * r + k - 3) % 8);
            if (k >= 3)
                exp_s[u][k - 3] = s;
            src_u.edge_at(u, s.sec, s.ns, s.slot);
        end
        rd_chk(`TSC_OFS_CTRL, 32'h0000_0503, "count");
        check_unit(u);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 12'h000;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
        exp_s = '{default: '0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check_unit(1);
        check_unit(0);
        rd_chk(12'h5fc, 32'h0000_0000, "unmapped");
        `CHK("irq_rst", 1'b0, irq)
        $display("test reset done");
        round(0, 0);
        rd_chk(`TSC_OFS_STATUS, 32'h0000_0003, "status");
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b1, `TSC_OFS_MASK, 32'h0000_000f, 4'he);
        rd_chk(`TSC_OFS_MASK, 32'h0000_0000, "mask_lane");
        bus(1'b1, `TSC_OFS_MASK, 32'h0000_0003, 4'hf);
        `CHK("irq_on", 1'b1, irq)
        bus(1'b1, `TSC_OFS_STATUS, 32'h0000_0001, 4'hf);
        rd_chk(`TSC_OFS_STATUS, 32'h0000_0002, "w1c");
        `CHK("irq_held", 1'b1, irq)
        bus(1'b1, `TSC_OFS_STATUS, 32'h0000_0002, 4'hf);
        `CHK("irq_off", 1'b0, irq)
        bus(1'b1, `TSC_OFS_S4_SEC, 32'hffff_ffff, 4'hf);
        bus(1'b1, `TSC_OFS_S5_NS, 32'hffff_ffff, 4'hf);
        check_unit(0);
        $display("test first round done");
        round(0, 1);
        bus(1'b1, `TSC_OFS_CTRL, 32'h0000_0000, 4'hf);
        src_u.edge_at(0, 32'h1234_5678, 30'h0abc_def0, 3'h4);
        src_u.edge_at(0, 32'h8765_4321, 30'h0123_4567, 3'h1);
        rd_chk(`TSC_OFS_CTRL, 32'h0000_0500, "count_off");
        check_unit(0);
        bus(1'b1, `TSC_OFS_CTRL, 32'h0000_0003, 4'hf);
        // counting stops at eight; the fourth extra edge is not counted
        for (int k = 0; k < 4; k++)
            src_u.edge_at(0, $random(seed), 30'($random(seed)), 3'h6);
        rd_chk(`TSC_OFS_CTRL, 32'h0000_0803, "count_full");
        $display("test second round done");
        round(1, 2);
        check_unit(0);
        rd_chk(`TSC_OFS_STATUS, 32'h0000_000f, "status_both");
        `CHK("irq_both", 1'b1, irq)
        bus(1'b1, `TSC_OFS_STATUS, 32'h0000_000f, 4'hf);
        `CHK("irq_clr", 1'b0, irq)
        $display("test unit select done");
        tally_and_finish();
    end
endmodule
